// file: serial_eeprom_asserts.sv
// Checker on the pins between the master end and the device end.
// Assumes the bench instantiates it beside the joining interface.
`timescale 1ns/1ns
module serial_eeprom_asserts
  import serial_eeprom_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic protect_select,
  input wire logic program_enable,
  input wire logic data_out,
  input wire logic data_out_en
);
  logic [15:0] low_cnt_reg;
  logic [5:0]  rise_cnt_reg;
  // Reset value lets the first frame after reset start at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_reg  <= 16'(MIN_DESELECT_CYCLES);
      rise_cnt_reg <= 6'h00;
    end else begin
      low_cnt_reg  <= chip_select ? 16'h0000 : low_cnt_reg + 16'h0001;
      rise_cnt_reg <= !chip_select ? 6'h00 :
                      rise_cnt_reg + 6'($rose(serial_clock));
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence held_low;
    !chip_select [*4];
  endsequence
  sequence in_frame;
    chip_select ##1 chip_select;
  endsequence
  deselect_float_a: assert property (held_low |-> !data_out_en)
    else $error("output driven while deselected");
  out_on_rise_a: assert property (
    data_out_en && $past(data_out_en) && $changed(data_out) |-> serial_clock)
    else $error("output changed outside a clock high phase");
  // The rise count lags the rise that opened the read by one cycle
  read_phase_a: assert property (
    chip_select && data_out_en |->
      rise_cnt_reg + 6'($rose(serial_clock)) >= 6'(1 + HEADER_BITS))
    else $error("output driven before header complete");
  deselect_gap_a: assert property (
    $rose(chip_select) |-> low_cnt_reg >= 16'(MIN_DESELECT_CYCLES))
    else $error("deselect gap too short");
  start_bit_a: assert property (
    $rose(serial_clock) && rise_cnt_reg == 6'h00 |-> serial_in)
    else $error("first bit is not one");
  pins_steady_a: assert property (
    in_frame |-> $stable(protect_select) && $stable(program_enable))
    else $error("select pins moved within a frame");
  din_setup_a: assert property (
    chip_select && $changed(serial_in) |-> !serial_clock)
    else $error("serial input moved while clock high");
  clk_idle_a: assert property (
    !chip_select && !$past(chip_select) |-> $stable(serial_clock))
    else $error("serial clock toggles outside a frame");
  frame_len_a: assert property (
    $fell(chip_select) |-> rise_cnt_reg >= 6'(1 + HEADER_BITS))
    else $error("frame ended before header complete");
endmodule : serial_eeprom_asserts

// file: serial_eeprom_device.sv
// Device end: serial front end clocked by the link's serial clock.
// Assumes a memory core that answers read_word and takes the write fields.
//
// Summary of operation
// - Selected only while chip select high
// - Deselected: ignore clock and input, float output
// - Chip select rise restarts state; master toggles
// - Chip select fall after write starts programming
// - Master holds select low one microsecond
// - Capture serial input on clock rise
// - Output changes only after clock rise
// - Output driven only while selected
// - Master shifts all fields serially, bit per clock
// - Protect select steers array or protect register
// - Start bit one; leading zeros ignored
// - Two opcode bits then eight address bits
// - Sixteen data bits, most significant first
// - Program enable gates write-type operations; here it only sets cmd_write_ok, program_start pulses regardless
`timescale 1ns/1ns
module serial_eeprom_device
  import serial_eeprom_pkg::*;
(
  serial_eeprom_if.device         pins,
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic [DATA_BITS-1:0] read_word,
  output logic [OPCODE_BITS-1:0]  cmd_opcode,
  output logic [ADDR_BITS-1:0]    cmd_addr,
  output logic [DATA_BITS-1:0]    cmd_data,
  output logic                    cmd_protect,
  output logic                    cmd_write_ok,
  output logic                    program_start
);
  typedef enum {ST_IDLE, ST_HEAD, ST_DATA, ST_READ, ST_DONE} dev_state_t;

  // Serial clock domain; async clear by deselect restarts the state
  wire sk_clk = pins.serial_clock;
  wire cs_rst_b = pins.chip_select & rst_b;

  dev_state_t           state_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [HEADER_BITS-1:0] head_reg;
  logic [DATA_BITS-1:0] data_reg;
  logic [DATA_BITS-1:0] out_reg;
  logic [ADDR_BITS-1:0] ptr_reg;
  logic                 first_reg;
  logic                 wr_tog_reg;
  logic                 prot_reg;
  logic                 drive_reg;

  wire last_head = (cnt_reg == CNT_W'(HEADER_BITS - 1));
  wire last_data = (cnt_reg == CNT_W'(DATA_BITS - 1));
  wire [OPCODE_BITS-1:0] op_w = head_reg[HEADER_BITS-2 -: OPCODE_BITS];
  wire is_read = (op_w == OP_READ);
  wire in_idle    = (state_reg == ST_IDLE);
  wire in_head    = (state_reg == ST_HEAD);
  wire in_data    = (state_reg == ST_DATA);
  wire take_start = in_idle & pins.chip_select & pins.serial_in;
  wire to_data    = (op_w == OP_WRITE) & !prot_reg;
  // Write-type: every header that is neither a read nor a data write, and the last bit of every data field
  wire mark_write = (in_head & last_head & !is_read & !to_data) |
                    (in_data & last_data);

  // Field registers sit outside the deselect reset: they must still
  // hold the finished frame when chip select falls and samples them
  always_ff @(posedge sk_clk or negedge rst_b) begin
    if (!rst_b) begin
      head_reg   <= '0;
      data_reg   <= '0;
      prot_reg   <= 1'b0;
      wr_tog_reg <= 1'b0;
    end else begin
      if (take_start) begin
        data_reg <= '0;
        prot_reg <= pins.protect_select;
      end
      if (in_head) begin
        head_reg <= {head_reg[HEADER_BITS-2:0], pins.serial_in};
      end
      if (in_data) begin
        data_reg <= {data_reg[DATA_BITS-2:0], pins.serial_in};
      end
      if (mark_write) begin
        wr_tog_reg <= ~wr_tog_reg;
      end
    end
  end

  // capture on rising clock edge while selected
  always_ff @(posedge sk_clk or negedge cs_rst_b) begin
    if (!cs_rst_b) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= '0;
      out_reg      <= '0;
      ptr_reg      <= '0;
      first_reg    <= 1'b0;
      drive_reg    <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pins.serial_in) begin
            state_reg <= ST_HEAD;
          end
        end
        ST_HEAD: begin
          cnt_reg  <= cnt_reg + CNT_W'(1);
          if (last_head) begin
            cnt_reg   <= '0;
            state_reg <= ST_DONE;
            if (is_read) begin
              state_reg <= ST_READ;
              ptr_reg   <= {head_reg[ADDR_BITS-2:0], pins.serial_in};
              first_reg <= 1'b1;
              drive_reg <= 1'b1;
            end else if (to_data) begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          cnt_reg  <= cnt_reg + CNT_W'(1);
          if (last_data) begin
            state_reg <= ST_DONE;
          end
        end
        ST_READ: begin
          // dummy zero, then MSB first, changed on the rise
          if (first_reg) begin
            first_reg <= 1'b0;
            out_reg   <= read_word;
            cnt_reg   <= '0;
          end else begin
            out_reg <= {out_reg[DATA_BITS-2:0], 1'b0};
            cnt_reg <= cnt_reg + CNT_W'(1);
            if (last_data) begin
              cnt_reg <= '0;
              ptr_reg <= ptr_reg + ADDR_BITS'(1);
              out_reg <= read_word;
            end
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Output comes straight from the shift register; it stays zero
  // through the dummy bit because the word loads one rise later
  assign pins.data_out    = out_reg[DATA_BITS-1];
  // drive only while selected and reading
  assign pins.data_out_en = drive_reg;

  // Programming start: the field registers move only on serial clock
  // rises within a frame, so they are settled at chip select fall.
  // A toggle marks each finished write-type frame, so a frame that
  // shifts nothing in cannot start programming a second time.
  logic                   wr_seen_reg;
  logic [2:0]             tog_sync_reg;
  logic [HEADER_BITS-1:0] head_hold_reg;
  logic [DATA_BITS-1:0]   data_hold_reg;
  logic                   prot_hold_reg;
  logic                   pe_hold_reg;
  always_ff @(negedge pins.chip_select or negedge rst_b) begin
    if (!rst_b) begin
      wr_seen_reg   <= 1'b0;
      head_hold_reg <= '0;
      data_hold_reg <= '0;
      prot_hold_reg <= 1'b0;
      pe_hold_reg   <= 1'b0;
    end else begin
      wr_seen_reg   <= wr_tog_reg;
      head_hold_reg <= head_reg;
      data_hold_reg <= data_reg;
      prot_hold_reg <= prot_reg;
      pe_hold_reg   <= pins.program_enable;
    end
  end

  // three-stage crossing of the toggle into sys_clk; the held
  // fields stand still for a whole frame, so they cross under its cover

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_sync_reg  <= '0;
      cmd_addr      <= '0;
      cmd_data      <= '0;
      cmd_protect   <= 1'b0;
      cmd_write_ok  <= 1'b0;
      program_start <= 1'b0;
      cmd_opcode    <= '0;
    end else begin
      tog_sync_reg  <= {tog_sync_reg[1:0], wr_seen_reg};
      program_start <= tog_sync_reg[2] ^ tog_sync_reg[1];
      if (tog_sync_reg[2] ^ tog_sync_reg[1]) begin
        cmd_opcode   <= head_hold_reg[HEADER_BITS-1 -: OPCODE_BITS];
        cmd_addr     <= head_hold_reg[ADDR_BITS-1:0];
        cmd_data     <= data_hold_reg;
        cmd_protect  <= prot_hold_reg;
        cmd_write_ok <= pe_hold_reg;
      end
    end
  end
  // Pointer is kept for a core that follows sequential reads
  wire unused_ok = &{1'b0, ptr_reg};
endmodule : serial_eeprom_device

// file: serial_eeprom_if.sv
// Pin bundle between the bus master and the EEPROM front end.
// Assumes the bench resolves the tri-state output from data_out_en.
`timescale 1ns/1ns
interface serial_eeprom_if;
  logic chip_select;
  logic serial_clock;
  logic serial_in;
  logic protect_select;
  logic program_enable;
  logic data_out;
  logic data_out_en;
  modport master (
    output chip_select, serial_clock, serial_in,
    output protect_select, program_enable,
    input  data_out, data_out_en
  );
  modport device (
    input  chip_select, serial_clock, serial_in,
    input  protect_select, program_enable,
    output data_out, data_out_en
  );
endinterface : serial_eeprom_if

// file: serial_eeprom_master.sv
// Master end: generates chip select, serial clock and serial input.
// Assumes the user holds cmd fields stable while busy is high.
`timescale 1ns/1ns
module serial_eeprom_master
  import serial_eeprom_pkg::*;
(
  serial_eeprom_if.master           pins,
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 req,
  input  wire logic [OPCODE_BITS-1:0] opcode,
  input  wire logic [ADDR_BITS-1:0] addr,
  input  wire logic [DATA_BITS-1:0] wdata,
  input  wire logic                 with_data,
  input  wire logic [CNT_W-1:0]     read_bits,
  input  wire logic                 protect_sel,
  input  wire logic                 prog_en,
  output logic                      busy,
  output logic [DATA_BITS-1:0]      rdata,
  output logic                      done
);
  typedef enum {M_IDLE, M_SHIFT, M_GAP} m_state_t;
  localparam int FRAME_BITS = 1 + HEADER_BITS + DATA_BITS;

  // Divider and gap counters are eight bits; the read sampler needs
  // a half period well above its three-stage synchroniser
  if (SK_HALF_CYCLES < 10 || SK_HALF_CYCLES > 256) begin : g_half_chk
    $error("serial clock half period out of range");
  end
  if (MIN_DESELECT_CYCLES > 255) begin : g_gap_chk
    $error("deselect gap too long for its counter");
  end

  m_state_t            state_reg;
  logic [FRAME_BITS-1:0] sh_reg;
  logic [5:0]          bits_reg;
  logic [7:0]          div_reg;
  logic [7:0]          gap_reg;
  logic [2:0]          do_sync_reg;
  logic                sk_reg;
  logic                cs_reg;

  wire half_done = (div_reg == 8'(SK_HALF_CYCLES - 1));
  wire rise = half_done & !sk_reg & (state_reg == M_SHIFT);
  wire fall = half_done & sk_reg;

  assign pins.chip_select    = cs_reg;
  assign pins.serial_clock   = sk_reg;
  assign pins.serial_in      = sh_reg[FRAME_BITS-1];
  assign pins.protect_select = protect_sel;
  assign pins.program_enable = prog_en;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= M_IDLE;
      sh_reg      <= '0;
      bits_reg    <= '0;
      div_reg     <= '0;
      gap_reg     <= '0;
      do_sync_reg <= '0;
      sk_reg      <= 1'b0;
      cs_reg      <= 1'b0;
      busy        <= 1'b0;
      rdata       <= '0;
      done        <= 1'b0;
    end else begin
      do_sync_reg <= {do_sync_reg[1:0], pins.data_out};
      done <= 1'b0;
      div_reg <= half_done ? 8'h00 : div_reg + 8'h01;
      case (state_reg)
        M_IDLE: begin
          sk_reg <= 1'b0;
          if (req) begin
            // start, opcode, address, data MSB first
            sh_reg    <= {1'b1, opcode, addr, wdata};
            bits_reg  <= 6'(1 + HEADER_BITS) +
                         (with_data ? 6'(DATA_BITS) : 6'(read_bits));
            cs_reg    <= 1'b1;
            busy      <= 1'b1;
            div_reg   <= '0;
            state_reg <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (rise) begin
            sk_reg <= 1'b1;
            // Sample once second and third stages agree
            if (do_sync_reg[2] == do_sync_reg[1]) begin
              rdata <= {rdata[DATA_BITS-2:0], do_sync_reg[2]};
            end
          end else if (fall) begin
            sk_reg   <= 1'b0;
            sh_reg   <= {sh_reg[FRAME_BITS-2:0], 1'b0};
            bits_reg <= bits_reg - 6'h01;
            if (bits_reg == 6'h01) begin
              cs_reg    <= 1'b0;
              gap_reg   <= '0;
              state_reg <= M_GAP;
            end
          end
        end
        M_GAP: begin
          // hold deselect at least the least deselect time
          gap_reg <= gap_reg + 8'h01;
          if (gap_reg == 8'(MIN_DESELECT_CYCLES)) begin
            busy      <= 1'b0;
            done      <= 1'b1;
            state_reg <= M_IDLE;
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end
endmodule : serial_eeprom_master

// file: serial_eeprom_pin_interface_bench.sv
// Bench joining the master end and the device end through the pins.
// Assumes the master makes the serial clock from sys_clk.
`timescale 1ns/1ns
module serial_eeprom_pin_interface_bench
  import serial_eeprom_pkg::*;
;
  logic                   sys_clk     = 1'b0;
  logic                   rst_b       = 1'b0;
  logic                   req         = 1'b0;
  logic [OPCODE_BITS-1:0] opcode      = 2'h0;
  logic [ADDR_BITS-1:0]   addr        = 8'h00;
  logic [DATA_BITS-1:0]   wdata       = 16'h0000;
  logic                   with_data   = 1'b0;
  logic [CNT_W-1:0]       read_bits   = 5'h00;
  logic                   protect_sel = 1'b0;
  logic                   prog_en     = 1'b0;
  logic [DATA_BITS-1:0]   read_word   = 16'hc35a;
  logic                   busy;
  logic                   done;
  logic                   cmd_protect;
  logic                   cmd_write_ok;
  logic                   program_start;
  logic [DATA_BITS-1:0]   rdata;
  logic [DATA_BITS-1:0]   cmd_data;
  logic [OPCODE_BITS-1:0] cmd_opcode;
  logic [ADDR_BITS-1:0]   cmd_addr;
  int                     miscompares = 0;
  int                     samples_checked = 0;
  int                     starts = 0;
  serial_eeprom_if pins ();
  serial_eeprom_master u_serial_eeprom_master (.pins(pins), .sys_clk,
    .rst_b, .req, .opcode, .addr, .wdata, .with_data, .read_bits,
    .protect_sel, .prog_en, .busy, .rdata, .done);
  serial_eeprom_device u_serial_eeprom_device (.pins(pins), .sys_clk,
    .rst_b, .read_word, .cmd_opcode, .cmd_addr, .cmd_data, .cmd_protect,
    .cmd_write_ok, .program_start);
  serial_eeprom_asserts u_serial_eeprom_asserts (.sys_clk, .rst_b,
    .chip_select(pins.chip_select), .serial_clock(pins.serial_clock),
    .serial_in(pins.serial_in), .protect_select(pins.protect_select),
    .program_enable(pins.program_enable), .data_out(pins.data_out),
    .data_out_en(pins.data_out_en));
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (program_start === 1'b1) starts++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic run_frame(input logic [1:0] op, input logic [7:0] a,
      input logic [15:0] d, input logic wd, input logic [4:0] rb,
      input logic ps, input logic pe);
    int n;
    @(negedge sys_clk);
    opcode = op;
    addr = a;
    wdata = d;
    with_data = wd;
    read_bits = rb;
    protect_sel = ps;
    prog_en = pe;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(done), 16'h0001);
  endtask : run_frame
  task automatic t_write();
    int s0;
    s0 = starts;
    run_frame(OP_WRITE, 8'ha5, 16'h9c36, 1'b1, 5'h00, 1'b0, 1'b1);
    check(16'(starts - s0), 16'h0001);
    check(16'(cmd_opcode), 16'(OP_WRITE));
    check(16'(cmd_addr), 16'h00a5);
    check(cmd_data, 16'h9c36);
    check(16'(cmd_protect), 16'h0000);
    check(16'(cmd_write_ok), 16'h0001);
  endtask : t_write
  task automatic t_read();
    int s0;
    s0 = starts;
    // Dummy bit plus one word
    run_frame(OP_READ, 8'h3c, 16'h0000, 1'b0, 5'h11, 1'b0, 1'b0);
    check(rdata, 16'hc35a);
    check(16'(starts - s0), 16'h0000);
  endtask : t_read
  task automatic t_ctrl();
    int s0;
    logic [1:0] ops [3];
    ops = '{OP_CTRL, OP_CLEAR, OP_WRITE};
    // Back-to-back frames also exercise the deselect gap; the last is
    // a protect-side write, which carries no data field
    for (int i = 0; i < 3; i++) begin
      s0 = starts;
      run_frame(ops[i], 8'hff, 16'h0000, 1'b0, 5'h00, 1'b1, 1'b0);
      check(16'(starts - s0), 16'h0001);
      check(16'(cmd_opcode), 16'(ops[i]));
      check(16'(cmd_addr), 16'h00ff);
      check(16'(cmd_protect), 16'h0001);
      check(16'(cmd_write_ok), 16'h0000);
    end
  endtask : t_ctrl
  task automatic wrap_up();
    $display("Compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // About 18k cycles expected; limit is well beyond that
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    t_write();
    t_read();
    t_ctrl();
    wrap_up();
  end
endmodule : serial_eeprom_pin_interface_bench

// file: serial_eeprom_pkg.sv
// Shared constants for the serial EEPROM pin interface.
// Assumes both ends import it whole.
package serial_eeprom_pkg;
  localparam int OPCODE_BITS   = 2;
  localparam int ADDR_BITS     = 8;
  localparam int DATA_BITS     = 16;
  localparam int HEADER_BITS   = OPCODE_BITS + ADDR_BITS;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_CTRL  = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h3;
  localparam int CNT_W         = 5;
  localparam int SYS_CLK_MHZ   = 100;
  // Least deselect time, in ns as printed (1 us)
  localparam int MIN_DESELECT_TIME_NS = 1000;
  localparam int MIN_DESELECT_CYCLES =
    (MIN_DESELECT_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  // Half period of the generated serial clock, in sys_clk cycles
  localparam int SK_HALF_CYCLES = 100;
endpackage : serial_eeprom_pkg
